// >>> rtl/svmc_pkg.sv
// Package of constants for the supply voltage monitor control block.
package svmc_pkg;

  // ****************************************************************
  // Register map (word index, byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0]  SVMC_IDX_SECOND_CTRL  = 8'h37;
  localparam logic [7:0]  SVMC_IDX_FIRST_CTRL   = 8'h36;
  localparam logic [7:0]  SVMC_IDX_DETECT_EN    = 8'h40;
  localparam logic [7:0]  SVMC_IDX_DETECT_STAT  = 8'h41;
  localparam logic [7:0]  SVMC_IDX_PROTECT      = 8'h42;
  localparam logic [7:0]  SVMC_IDX_CLOCK_CTRL   = 8'h43;

  // ****************************************************************
  // Field positions of the monitor control, detect, protect and clock registers
  // ****************************************************************
  localparam int SVMC_B_ENABLE    = 0;
  localparam int SVMC_B_BYPASS    = 1;
  localparam int SVMC_B_CROSS     = 2;
  localparam int SVMC_B_WDT       = 3;
  localparam int SVMC_B_DIV_LO    = 4;
  localparam int SVMC_B_DIV_HI    = 5;
  localparam int SVMC_B_MODE      = 6;
  localparam int SVMC_B_EDGE      = 7;
  localparam int SVMC_B_DET1_EN   = 6;
  localparam int SVMC_B_DET2_EN   = 7;
  localparam int SVMC_B_LEVEL2    = 3;
  localparam int SVMC_B_PROTECT   = 3;
  localparam int SVMC_B_OSC_STOP  = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  SVMC_RST_SECOND_CTRL = 8'h00;
  localparam logic [7:0]  SVMC_RST_FIRST_CTRL  = 8'h00;
  localparam logic [7:0]  SVMC_RST_DETECT_EN   = 8'h00;
  localparam logic [7:0]  SVMC_RST_PROTECT     = 8'h00;
  localparam logic        SVMC_RST_OSC_STOP    = 1'b1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SVMC_CLK_HZ        = 40000000;
  localparam int SVMC_OSC_HZ        = 125000;
  localparam int SVMC_OSC_CYCLES    = SVMC_CLK_HZ / SVMC_OSC_HZ;
  localparam int SVMC_SETTLE_US     = 100;
  localparam int SVMC_SETTLE_CYCLES = (SVMC_SETTLE_US * (SVMC_CLK_HZ / 1000000));
  localparam int SVMC_FLT_SAMPLES   = 2;

endpackage

// >>> rtl/svmc_filter.sv
// Digital majority filter for one supply comparator.
`timescale 1ns/1ps
`default_nettype none

module svmc_filter
  import svmc_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       sample_i,
  input  wire logic       level_i,
  input  wire logic       bypass_i,
  output logic            level_o,
  output logic            rise_o,
  output logic            fall_o
);

  logic [1:0] hist_r;
  logic [1:0] hist_nxt;
  logic       out_r;
  logic       out_nxt;

  // ****************************************************************
  // Sample history and qualified level
  // ****************************************************************

  // Two consecutive equal samples move the filtered level; bypass follows input.
  always_comb
  begin
    hist_nxt = hist_r;
    out_nxt  = out_r;
    if (bypass_i)
    begin
      out_nxt  = level_i;
      hist_nxt = {level_i, level_i};
    end
    else if (sample_i)
    begin
      hist_nxt = {hist_r[0], level_i};
      if (hist_r[0] == level_i)
      begin
        out_nxt = level_i;
      end
    end
  end

  // Registers the filter state.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      hist_r <= 2'h3;                                        // Matches the supply-above idle level.
      out_r  <= 1'b1;                                        // So no false edge follows reset.
    end
    else
    begin
      hist_r <= hist_nxt;
      out_r  <= out_nxt;
    end
  end

  // Edge pulses of the filtered level, one clock wide.
  assign level_o = out_r;
  assign rise_o  = out_nxt & ~out_r;
  assign fall_o  = ~out_nxt & out_r;

endmodule

`default_nettype wire

// >>> rtl/svmc_top.sv
// Supply voltage monitor control: registers, filters, reset and interrupt outputs.
`timescale 1ns/1ps
`default_nettype none

module svmc_top
  import svmc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SVMC_SETTLE_CYCLES
)
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        WARM_RST_I,
  input  wire logic        WDT_EVENT_I,
  input  wire logic        CMP1_ABOVE_I,
  input  wire logic        CMP2_ABOVE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [9:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             FIRST_RESET_O,
  output logic             SECOND_RESET_O,
  output logic             SECOND_IRQ_O
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] cmp1_s_r;
  logic [1:0] cmp2_s_r;
  logic       cmp1;
  logic       cmp2;

  // Two flip-flops on each comparator pin.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      cmp1_s_r <= 2'h3;
      cmp2_s_r <= 2'h3;
    end
    else
    begin
      cmp1_s_r <= {cmp1_s_r[0], CMP1_ABOVE_I};
      cmp2_s_r <= {cmp2_s_r[0], CMP2_ABOVE_I};
    end
  end

  assign cmp1 = cmp1_s_r[1];
  assign cmp2 = cmp2_s_r[1];

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************
  logic [7:0] ctl2_r;
  logic [7:0] ctl2_nxt;
  logic [7:0] ctl1_r;
  logic [7:0] ctl1_nxt;
  logic [7:0] den_r;
  logic [7:0] den_nxt;
  logic       prot_r;
  logic       prot_nxt;
  logic       osc_stop_r;
  logic       osc_stop_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic [7:0] rdat_r;
  logic [7:0] rdat_nxt;
  logic       wr;
  logic       wr8;
  logic [7:0] idx;
  logic       cross_ev;
  logic       lvl2_ok;

  assign idx = ADR_I[9:2];
  assign wr  = CYC_I & STB_I & WE_I & ~ack_r;
  assign wr8 = wr & SEL_I[0];

  // Computes register next values and the read word.
  always_comb
  begin
    ctl2_nxt     = ctl2_r;
    ctl1_nxt     = ctl1_r;
    den_nxt      = den_r;
    prot_nxt     = prot_r;
    osc_stop_nxt = osc_stop_r;
    ack_nxt      = CYC_I & STB_I & ~ack_r;
    rdat_nxt     = 8'h00;
    if (wr8 && idx == SVMC_IDX_SECOND_CTRL && prot_r)
    begin
      ctl2_nxt = DAT_I[7:0];
      ctl2_nxt[SVMC_B_CROSS] = ctl2_r[SVMC_B_CROSS] & DAT_I[SVMC_B_CROSS];
      ctl2_nxt[SVMC_B_WDT]   = ctl2_r[SVMC_B_WDT] & DAT_I[SVMC_B_WDT];
    end
    if (wr8 && idx == SVMC_IDX_FIRST_CTRL && prot_r)
    begin
      ctl1_nxt = DAT_I[7:0];
    end
    if (wr8 && idx == SVMC_IDX_DETECT_EN && prot_r)
    begin
      den_nxt = DAT_I[7:0];
    end
    if (wr8 && idx == SVMC_IDX_PROTECT)
    begin
      prot_nxt = DAT_I[SVMC_B_PROTECT];
    end
    if (wr8 && idx == SVMC_IDX_CLOCK_CTRL)
    begin
      osc_stop_nxt = DAT_I[SVMC_B_OSC_STOP];
    end
    // Hardware sets win over a software clear in the same cycle.
    if (cross_ev && den_r[SVMC_B_DET2_EN])
    begin
      ctl2_nxt[SVMC_B_CROSS] = 1'b1;
    end
    if (WDT_EVENT_I)
    begin
      ctl2_nxt[SVMC_B_WDT] = 1'b1;
    end
    case (idx)
      SVMC_IDX_SECOND_CTRL: rdat_nxt = ctl2_r;
      SVMC_IDX_FIRST_CTRL:  rdat_nxt = ctl1_r & 8'hf7;
      SVMC_IDX_DETECT_EN:   rdat_nxt = den_r;
      SVMC_IDX_DETECT_STAT: rdat_nxt = {4'h0, lvl2_ok, 3'h0};
      SVMC_IDX_PROTECT:     rdat_nxt = {4'h0, prot_r, 3'h0};
      SVMC_IDX_CLOCK_CTRL:  rdat_nxt = {3'h0, osc_stop_r, 4'h0};
      default:              rdat_nxt = 8'h00;
    endcase
  end

  // Registers; flags survive a warm reset.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ctl2_r     <= SVMC_RST_SECOND_CTRL;
      ctl1_r     <= SVMC_RST_FIRST_CTRL;
      den_r      <= SVMC_RST_DETECT_EN;
      prot_r     <= 1'b0;
      osc_stop_r <= SVMC_RST_OSC_STOP;
      ack_r      <= 1'b0;
      rdat_r     <= 8'h00;
    end
    else if (WARM_RST_I)
    begin
      ctl2_r     <= {4'h0, ctl2_nxt[SVMC_B_WDT], ctl2_nxt[SVMC_B_CROSS], 2'h0};
      ctl1_r     <= ctl1_r;
      den_r      <= den_r;
      prot_r     <= 1'b0;
      osc_stop_r <= SVMC_RST_OSC_STOP;
      ack_r      <= 1'b0;
      rdat_r     <= 8'h00;
    end
    else
    begin
      ctl2_r     <= ctl2_nxt;
      ctl1_r     <= ctl1_nxt;
      den_r      <= den_nxt;
      prot_r     <= prot_nxt;
      osc_stop_r <= osc_stop_nxt;
      ack_r      <= ack_nxt;
      rdat_r     <= rdat_nxt;
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = {24'h000000, rdat_r};

  // ****************************************************************
  // Oscillator tick, sampling dividers and settle timer
  // ****************************************************************
  logic [15:0] osc_cnt_r;
  logic [15:0] osc_cnt_nxt;
  logic [2:0]  div_cnt_r;
  logic [2:0]  div_cnt_nxt;
  logic [31:0] settle_r;
  logic [31:0] settle_nxt;
  logic        osc_tick;
  logic        smp1;
  logic        smp2;

  // Oscillator tick counter held at zero while the clock stop bit is set, a divide-by-8 prescale and the settle counter.
  always_comb
  begin
    osc_tick    = ~osc_stop_r && osc_cnt_r == 16'(SVMC_OSC_CYCLES - 1);
    osc_cnt_nxt = osc_stop_r ? 16'h0000 : (osc_tick ? 16'h0000 : osc_cnt_r + 16'h0001);
    div_cnt_nxt = osc_tick ? div_cnt_r + 3'h1 : div_cnt_r;
    settle_nxt  = settle_r;
    if (!den_r[SVMC_B_DET2_EN])
    begin
      settle_nxt = 32'h0;
    end
    else if (settle_r != 32'(SETTLE_CYCLES))
    begin
      settle_nxt = settle_r + 32'h1;
    end
  end

  // Registers the timing counters.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      osc_cnt_r <= 16'h0000;
      div_cnt_r <= 3'h0;
      settle_r  <= 32'h0;
    end
    else
    begin
      osc_cnt_r <= osc_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      settle_r  <= settle_nxt;
    end
  end

  // Picks the sampling enable for a divide select of 1, 2, 4 or 8.
  function automatic logic pick_tick(input logic [1:0] sel, input logic [2:0] cnt,
                                     input logic tick);
    logic r;
    case (sel)
      2'h0:    r = tick;
      2'h1:    r = tick & (cnt[0] == 1'b0);
      2'h2:    r = tick & (cnt[1:0] == 2'h0);
      default: r = tick & (cnt == 3'h0);
    endcase
    return r;
  endfunction

  assign smp1    = pick_tick(ctl1_r[SVMC_B_DIV_HI:SVMC_B_DIV_LO], div_cnt_r, osc_tick);
  assign smp2    = pick_tick(ctl2_r[SVMC_B_DIV_HI:SVMC_B_DIV_LO], div_cnt_r, osc_tick);
  assign lvl2_ok = den_r[SVMC_B_DET2_EN] && settle_r == 32'(SETTLE_CYCLES) && cmp2;

  // ****************************************************************
  // Filters
  // ****************************************************************
  logic lvl1_f;
  logic lvl2_f;
  logic rise2;
  logic fall2;

  // First monitor filter; its bypass bit picks direct or filtered level.
  svmc_filter u_filt1 (
    .CLK_I    (CLK_I),
    .RST_I    (RST_I),
    .sample_i (smp1),
    .level_i  (cmp1),
    .bypass_i (ctl1_r[SVMC_B_BYPASS]),
    .level_o  (lvl1_f),
    .rise_o   (),
    .fall_o   ()
  );

  // Second monitor filter.
  svmc_filter u_filt2 (
    .CLK_I    (CLK_I),
    .RST_I    (RST_I),
    .sample_i (smp2),
    .level_i  (cmp2),
    .bypass_i (ctl2_r[SVMC_B_BYPASS]),
    .level_o  (lvl2_f),
    .rise_o   (rise2),
    .fall_o   (fall2)
  );

  // ****************************************************************
  // Request generation
  // ****************************************************************
  logic act2;
  logic irq_r;
  logic irq_nxt;
  logic rst2_r;
  logic rst2_nxt;
  logic rst1_r;
  logic rst1_nxt;

  // Filtered: both directions; bypassed: the edge chosen by the edge bit.
  assign cross_ev = ctl2_r[SVMC_B_BYPASS] ?
                    (ctl2_r[SVMC_B_EDGE] ? fall2 : rise2) : (rise2 | fall2);
  assign act2     = ctl2_r[SVMC_B_ENABLE] & den_r[SVMC_B_DET2_EN];

  // Computes interrupt pulse and both reset levels.
  always_comb
  begin
    irq_nxt  = act2 & cross_ev & ~ctl2_r[SVMC_B_MODE];
    rst2_nxt = act2 & ctl2_r[SVMC_B_MODE] & (rst2_r | (cross_ev & fall2));
    if (rst2_r && lvl2_f)
    begin
      rst2_nxt = 1'b0;
    end
    rst1_nxt = ctl1_r[SVMC_B_ENABLE] & den_r[SVMC_B_DET1_EN] & ~lvl1_f;
  end

  // Registers the request outputs.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      irq_r  <= 1'b0;
      rst2_r <= 1'b0;
      rst1_r <= 1'b0;
    end
    else
    begin
      irq_r  <= irq_nxt;
      rst2_r <= rst2_nxt;
      rst1_r <= rst1_nxt;
    end
  end

  assign SECOND_IRQ_O   = irq_r;
  assign SECOND_RESET_O = rst2_r;
  assign FIRST_RESET_O  = rst1_r;

endmodule

`default_nettype wire

// >>> tb/svmc_monitor.sv
// Checker that watches the ports of the monitor control block.
`timescale 1ns/1ps
`default_nettype none

module svmc_monitor
(
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        CMP1_ABOVE_I,
  input wire logic        CMP2_ABOVE_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        FIRST_RESET_O,
  input wire logic        SECOND_RESET_O,
  input wire logic        SECOND_IRQ_O
);
  // ****
  // Bus answer
  // ****
  // All checks share the one clock and the full reset.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_ack_answer: assert property ((CYC_I && STB_I && !ACK_O) |=> ACK_O)
    else $error("request not acknowledged after one cycle");
  a_ack_once: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("acknowledge without a request");
  a_dat_upper: assert property (DAT_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // ****
  // Monitor outputs
  // ****
  // Requests are short pulses and resets follow a low supply.
  a_irq_pulse: assert property (SECOND_IRQ_O |=> !SECOND_IRQ_O)
    else $error("interrupt pulse longer than one cycle");
  a_quiet_reset: assert property ($fell(RST_I) |-> !ACK_O && !SECOND_IRQ_O
    && !FIRST_RESET_O && !SECOND_RESET_O)
    else $error("outputs active right after reset");
  a_first_low: assert property ($rose(FIRST_RESET_O) |-> !CMP1_ABOVE_I)
    else $error("first reset raised with supply above");
  a_second_low: assert property ($rose(SECOND_RESET_O) |-> !CMP2_ABOVE_I)
    else $error("second reset raised with supply above");
endmodule

bind svmc_top svmc_monitor u_svmc_monitor (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .CMP1_ABOVE_I(CMP1_ABOVE_I), .CMP2_ABOVE_I(CMP2_ABOVE_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .FIRST_RESET_O(FIRST_RESET_O), .SECOND_RESET_O(SECOND_RESET_O),
  .SECOND_IRQ_O(SECOND_IRQ_O));

`default_nettype wire

// >>> tb/svmc_supply_model.sv
// Model of the two supply comparators at the far side.
`timescale 1ns/1ps
`default_nettype none

module svmc_supply_model
(
  input  wire logic CLK_I,
  input  wire logic supply1_hi_i,
  input  wire logic supply2_hi_i,
  output logic      cmp1_o,
  output logic      cmp2_o
);
  // Comparators answer one cycle after the supply moves.
  always_ff @(posedge CLK_I)
  begin
    cmp1_o <= supply1_hi_i;
    cmp2_o <= supply2_hi_i;
  end
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// Testbench of the supply voltage monitor control block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import svmc_pkg::*;

  localparam int         P    = SVMC_OSC_CYCLES;
  localparam logic [9:0] A_S2 = 10'h0dc;
  localparam logic [9:0] A_S1 = 10'h0d8;
  localparam logic [9:0] A_EN = 10'h100;
  localparam logic [9:0] A_ST = 10'h104;
  localparam logic [9:0] A_PR = 10'h108;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        warm = 1'b0;
  logic        wdt = 1'b0;
  logic        sup1 = 1'b1;
  logic        sup2 = 1'b1;
  logic        cmp1;
  logic        cmp2;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o;
  logic        ack;
  logic        frst;
  logic        srst;
  logic        irq;
  int          fails = 0;
  int          checks = 0;
  int          irqs = 0;
  int          lat;

  // Clock of 25 ns and a count of interrupt pulses.
  always #12.5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;

  svmc_top #(.SETTLE_CYCLES(4)) u_svmc_top (.CLK_I(clk), .RST_I(rst), .WARM_RST_I(warm),
    .WDT_EVENT_I(wdt), .CMP1_ABOVE_I(cmp1), .CMP2_ABOVE_I(cmp2), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
    .FIRST_RESET_O(frst), .SECOND_RESET_O(srst), .SECOND_IRQ_O(irq));
  svmc_supply_model u_svmc_supply_model (.CLK_I(clk), .supply1_hi_i(sup1),
    .supply2_hi_i(sup2), .cmp1_o(cmp1), .cmp2_o(cmp2));

  // ****
  // Tasks
  // ****
  task end_sim();
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One classic cycle, held until the acknowledge is sampled.
  task wb(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) fails++;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  // Unlocked rewrite, then a second pass that clears the crossing flag.
  task ctl(input logic [7:0] d);
    wr(A_PR, 8'h08);
    wr(A_S2, d);
    wr(A_PR, 8'h08);
    wr(A_S2, d & 8'hfb);
  endtask

  // Moves the second supply and counts cycles until an interrupt.
  task edge2(input logic v, input int lim, output int n);
    int base;
    base = irqs;
    n = 0;
    sup2 <= v;
    while (irqs == base && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(A_S2, 8'h00);
    rd(10'h3fc, 8'h00);
    wr(A_S2, 8'h01);
    rd(A_S2, 8'h00);
    wr(A_PR, 8'h08);
    wr(A_EN, 8'h80);
    wr(10'h10c, 8'h00);
    sup1 <= 1'b0;
    repeat (20) @(posedge clk);
    rd(A_ST, 8'h08);
    sup1 <= 1'b1;
    ctl(8'h83);
    edge2(1'b0, 20, lat);
    chk({7'h00, lat < 20}, 8'h01);
    rd(A_S2, 8'h87);
    wr(A_S2, 8'h87);
    rd(A_S2, 8'h87);
    wr(A_S2, 8'h83);
    rd(A_S2, 8'h83);
    edge2(1'b1, 40, lat);
    chk({7'h00, lat == 40}, 8'h01);
    ctl(8'h82);
    edge2(1'b0, 40, lat);
    chk({7'h00, lat == 40}, 8'h01);
    rd(A_S2, 8'h86);
    sup2 <= 1'b1;
    ctl(8'hc3);
    edge2(1'b0, 40, lat);
    chk({7'h00, lat == 40}, 8'h01);
    chk({7'h00, srst}, 8'h01);
    sup2 <= 1'b1;
    repeat (20) @(posedge clk);
    chk({7'h00, srst}, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      ctl(8'(8'h01 | (k << 4)));
      repeat (4 * (P << k)) @(posedge clk);
      edge2(1'b0, 3 * (P << k), lat);
      chk({7'h00, lat > (P << k) && lat <= 2 * (P << k) + 16}, 8'h01);
      edge2(1'b1, 3 * (P << k), lat);
      chk({7'h00, lat > (P << k) && lat <= 2 * (P << k) + 16}, 8'h01);
    end
    ctl(8'h01);
    sup2 <= 1'b0;
    repeat (100) @(posedge clk);
    edge2(1'b1, 3 * P, lat);
    chk({7'h00, lat == 3 * P}, 8'h01);
    wr(A_PR, 8'h08);
    wr(A_EN, 8'hc0);
    repeat (8) @(posedge clk);
    wr(A_S1, 8'hc2);
    wr(A_S1, 8'hc3);
    sup1 <= 1'b0;
    repeat (20) @(posedge clk);
    chk({7'h00, frst}, 8'h01);
    sup1 <= 1'b1;
    repeat (20) @(posedge clk);
    chk({7'h00, frst}, 8'h00);
    ctl(8'h82);
    wdt <= 1'b1;
    sup2 <= 1'b0;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (20) @(posedge clk);
    rd(A_S2, 8'h8e);
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    rd(A_S2, 8'h0c);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_S2, 8'h00);
    end_sim();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule

`default_nettype wire
